// >>> design/gcps_pin_mux.sv
// Purpose: registered mux of seven pads between GPIO and alt functions
// Assumes: all inputs synchronous to core_clk
// Notes: index 6..1 are pins 7..2, index 0 is pin 1
`timescale 1ns/1ps
module gcps_pin_mux
  import gcps_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Selection
  input  wire logic [7:0] pin_sel,
  // Pads
  input  wire logic [6:0] pad_in,
  output logic      [6:0] pad_out,
  output logic      [6:0] pad_oe,
  // GPIO side
  input  wire logic [6:0] gp_out,
  input  wire logic [6:0] gp_oe,
  output logic      [6:0] gp_in,
  // Alternate side for pins 7..2
  input  wire logic [6:1] alt_out,
  input  wire logic [6:1] alt_oe,
  output logic      [6:1] alt_in,
  // Alternate outputs for pin 1
  input  wire logic       fan2_out,
  input  wire logic       hood_out
);

  // Pins 7..2: one select bit each
  genvar i;
  generate
    for (i = 1; i <= 6; i++)
    begin : g_pin
      localparam int SB = i - 1 + PS2_SINGLE_LSB;
      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          pad_out[i] <= 1'b0;
          pad_oe[i]  <= 1'b0;
          gp_in[i]   <= 1'b0;
          alt_in[i]  <= 1'b0;
        end
        else
        begin
          pad_out[i] <= pin_sel[SB] ? alt_out[i] : gp_out[i];
          pad_oe[i]  <= pin_sel[SB] ? alt_oe[i] : gp_oe[i];
          gp_in[i]   <= pin_sel[SB] ? 1'b0 : pad_in[i];
          alt_in[i]  <= pin_sel[SB] ? pad_in[i] : 1'b0;
        end
      end
      a_pin_route: assert property (@(posedge core_clk) disable iff (rst)
        pin_sel[SB] |=> pad_out[i] == $past(alt_out[i]))
        else $error("pad not driven by alternate function");
    end
  endgenerate

  // Pin 1: reserved code leaves the pad undriven
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pad_out[0] <= 1'b0;
      pad_oe[0]  <= 1'b0;
      gp_in[0]   <= 1'b0;
    end
    else
    begin
      case (pin_sel[PS2_PIN1_LSB +: 2])
        PIN1_GPIO:
        begin
          pad_out[0] <= gp_out[0];
          pad_oe[0]  <= gp_oe[0];
        end
        PIN1_FAN2:
        begin
          pad_out[0] <= fan2_out;
          pad_oe[0]  <= 1'b1;
        end
        PIN1_HOOD:
        begin
          pad_out[0] <= hood_out;
          pad_oe[0]  <= 1'b1;
        end
        default:
        begin
          pad_out[0] <= 1'b0;
          pad_oe[0]  <= 1'b0;
        end
      endcase
      gp_in[0] <= (pin_sel[PS2_PIN1_LSB +: 2] == PIN1_GPIO) & pad_in[0];
    end
  end

endmodule // gcps_pin_mux

// >>> design/gcps_top.sv
// Purpose: global config register and pin select register behind APB
// Assumes: APB master, one clock, synchronous active-high reset
// Notes: registers answer with zero wait states
//
// Notes on behaviour
// - Lock bit, once set, cannot be cleared by software; reset only.
// - Lock set makes all pin-function select bits read-only.
// - Bit 6 routes upper pin group to parallel interrupt inputs.
// - DMA wait states: 01 two, 10 six, 11 twelve, 00 reserved.
// - I/O wait states: 00 zero, 01 two, 10 six, 11 twelve.
// - Software reset bit reads zero; writing zero does nothing.
// - Writing one resets logical devices and wake-up unit, not lock.
// - Global enable low disables all devices except wake-up unit.
// - Global enable high: each device follows its own activate bit.
// - Bit 7 picks gp_port_05 or kbc_port_line_17 for its pin.
// - Bit 6 picks gp_port_04 or kbc_port_line_12 for its pin.
// - Bit 5 picks gp_port_03 or fan_pwm_out_0 for its pin.
// - Bit 4 picks gp_port_02 or fan_tach_in_0 for its pin.
// - Bit 3 picks gp_port_01 or fan_pwm_out_1 for its pin.
// - Bit 2 picks gp_port_00 or fan_tach_in_1 for its pin.
// - Bits 1-0: gp_port_34, fan_pwm_out_2, hood lock, reserved.
// - Each bit acts by its access type on writes.
`timescale 1ns/1ps
module gcps_top
  import gcps_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int N_DEV  = 8
)
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Device control
  input  wire logic [N_DEV-1:0]  dev_activate,
  output logic      [N_DEV-1:0]  dev_enable,
  output logic                   dev_soft_reset,
  output logic                   wake_unit_reset,
  output logic                   pirq_route,
  output logic                   pin_sel_lock,
  output logic      [3:0]        dma_wait_count,
  output logic      [3:0]        io_wait_count,
  // Pads, index 6..1 pins 7..2, index 0 pin 1
  input  wire logic [6:0]        pad_in,
  output logic      [6:0]        pad_out,
  output logic      [6:0]        pad_oe,
  // GPIO side, same indexing
  input  wire logic [6:0]        gp_out,
  input  wire logic [6:0]        gp_oe,
  output logic      [6:0]        gp_in,
  // Keyboard controller lines
  input  wire logic              kbc_port_line_17_out,
  input  wire logic              kbc_port_line_17_oe,
  output logic                   kbc_port_line_17_in,
  input  wire logic              kbc_port_line_12_out,
  input  wire logic              kbc_port_line_12_oe,
  output logic                   kbc_port_line_12_in,
  // Fan and hood functions
  input  wire logic              fan_pwm_out_0,
  input  wire logic              fan_pwm_out_1,
  input  wire logic              fan_pwm_out_2,
  input  wire logic              chassis_hood_lock_out,
  output logic                   fan_tach_in_0,
  output logic                   fan_tach_in_1
);

  // Register fields
  logic             lock_r;
  logic             pirq_r;
  logic [WS_W-1:0]  dma_r;
  logic [WS_W-1:0]  io_r;
  logic             gen_r;
  logic [7:0]       ps2_r;
  logic             hit1_r;
  logic             hit2_r;
  logic             setup;
  logic             wr_ok;
  logic             wr1;
  logic             wr2;
  logic [7:0]       gc1_rd;
  logic [6:1]       alt_out;
  logic [6:1]       alt_oe;
  logic [6:1]       alt_in;

  // Word address match, index times four
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction

  // Bus phase decode
  assign setup = psel & ~penable;
  assign wr_ok = psel & penable & pready & pwrite & pstrb[0] & ~pslverr;
  assign wr1   = wr_ok & hit1_r;
  assign wr2   = wr_ok & hit2_r;

  // Software reset field always reads as zero
  assign gc1_rd = {lock_r, pirq_r, dma_r, io_r, 1'b0, gen_r};

  // APB answer: decode in setup, ready in first access cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      hit1_r  <= 1'b0;
      hit2_r  <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      hit1_r  <= setup & reg_hit(paddr, GC1_IDX);
      hit2_r  <= setup & reg_hit(paddr, PS2_IDX);
      pslverr <= setup & ~reg_hit(paddr, GC1_IDX)
                       & ~reg_hit(paddr, PS2_IDX);
      if (setup && reg_hit(paddr, GC1_IDX))
        prdata <= {24'h00_0000, gc1_rd};
      else if (setup && reg_hit(paddr, PS2_IDX))
        prdata <= {24'h00_0000, ps2_r};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // Lock is set-only; software has no clear path
  always_ff @(posedge core_clk)
  begin
    if (rst)
      lock_r <= GC1_RESET[GC1_LOCK_BIT];
    else if (wr1 && pwdata[GC1_LOCK_BIT])
      lock_r <= 1'b1;
  end

  // Pin-group select in config one, frozen by lock
  always_ff @(posedge core_clk)
  begin
    if (rst)
      pirq_r <= GC1_RESET[GC1_PIRQ_BIT];
    else if (wr1 && !lock_r)
      pirq_r <= pwdata[GC1_PIRQ_BIT];
  end

  // Wait-state fields; a reserved DMA code keeps the old value
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dma_r <= GC1_RESET[GC1_DMA_LSB +: WS_W];
      io_r  <= GC1_RESET[GC1_IO_LSB +: WS_W];
    end
    else if (wr1)
    begin
      if (pwdata[GC1_DMA_LSB +: WS_W] != WS_CODE_0)
        dma_r <= pwdata[GC1_DMA_LSB +: WS_W];
      io_r <= pwdata[GC1_IO_LSB +: WS_W];
    end
  end

  // Global enable updates even when locked
  always_ff @(posedge core_clk)
  begin
    if (rst)
      gen_r <= GC1_RESET[GC1_GEN_BIT];
    else if (wr1)
      gen_r <= pwdata[GC1_GEN_BIT];
  end

  // Pin select two, whole register is pin selection
  always_ff @(posedge core_clk)
  begin
    if (rst)
      ps2_r <= PS2_RESET;
    else if (wr2 && !lock_r)
      ps2_r <= pwdata[7:0];
  end

  // Soft reset pulses; lock and config fields are untouched
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dev_soft_reset  <= 1'b0;
      wake_unit_reset <= 1'b0;
    end
    else
    begin
      dev_soft_reset  <= wr1 & pwdata[GC1_SWRST_BIT];
      wake_unit_reset <= wr1 & pwdata[GC1_SWRST_BIT];
    end
  end

  // Decoded outputs, one cycle behind the fields
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dev_enable     <= '0;
      dma_wait_count <= WS_NONE;
      io_wait_count  <= WS_NONE;
      pirq_route     <= 1'b0;
      pin_sel_lock   <= 1'b0;
    end
    else
    begin
      // Wake-up unit takes no enable from here, so it keeps running
      dev_enable     <= gen_r ? dev_activate : '0;
      dma_wait_count <= gcps_ws_count(dma_r);
      io_wait_count  <= gcps_ws_count(io_r);
      pirq_route     <= pirq_r;
      pin_sel_lock   <= lock_r;
    end
  end

  // Alternate function wiring; PWM always drives, tach never does
  assign alt_out = {kbc_port_line_17_out, kbc_port_line_12_out,
                    fan_pwm_out_0, 1'b0, fan_pwm_out_1, 1'b0};
  assign alt_oe  = {kbc_port_line_17_oe, kbc_port_line_12_oe,
                    1'b1, 1'b0, 1'b1, 1'b0};
  assign kbc_port_line_17_in = alt_in[6];
  assign kbc_port_line_12_in = alt_in[5];
  assign fan_tach_in_0       = alt_in[3];
  assign fan_tach_in_1       = alt_in[1];

  // Pad multiplexer, registered
  gcps_pin_mux u_mux (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_sel  (ps2_r),
    .pad_in   (pad_in),
    .pad_out  (pad_out),
    .pad_oe   (pad_oe),
    .gp_out   (gp_out),
    .gp_oe    (gp_oe),
    .gp_in    (gp_in),
    .alt_out  (alt_out),
    .alt_oe   (alt_oe),
    .alt_in   (alt_in),
    .fan2_out (fan_pwm_out_2),
    .hood_out (chassis_hood_lock_out)
  );

  // Checks
  a_lock_sticky: assert property (@(posedge core_clk) disable iff (rst)
    lock_r |=> lock_r && pin_sel_lock)
    else $error("lock bit cleared without reset");

  a_lock_freeze: assert property (@(posedge core_clk) disable iff (rst)
    lock_r && wr2 |=> $stable(ps2_r) ##1 $stable(ps2_r))
    else $error("pin select changed while locked");

  a_lock_partial: assert property (@(posedge core_clk) disable iff (rst)
    lock_r && wr1 |=> $stable(pirq_r)
                      && gen_r == $past(pwdata[GC1_GEN_BIT]))
    else $error("locked write handled wrongly");

  a_pirq_route: assert property (@(posedge core_clk) disable iff (rst)
    wr1 && !lock_r |-> ##2 pirq_route == $past(pwdata[GC1_PIRQ_BIT], 2))
    else $error("pin group route not updated");

  a_dma_count: assert property (@(posedge core_clk) disable iff (rst)
    dma_r == WS_CODE_3 |=> dma_wait_count == WS_TWELVE)
    else $error("dma wait count wrong");

  a_dma_legal: assert property (@(posedge core_clk) disable iff (rst)
    dma_r != WS_CODE_0)
    else $error("reserved dma code stored");

  a_io_count: assert property (@(posedge core_clk) disable iff (rst)
    io_r == WS_CODE_1 |=> io_wait_count == WS_TWO)
    else $error("io wait count wrong");

  a_swrst_read: assert property (@(posedge core_clk) disable iff (rst)
    pready && hit1_r |-> !prdata[GC1_SWRST_BIT])
    else $error("soft reset bit read as one");

  a_swrst_pulse: assert property (@(posedge core_clk) disable iff (rst)
    wr1 && pwdata[GC1_SWRST_BIT] |=> dev_soft_reset && wake_unit_reset
      ##1 !dev_soft_reset && $stable(lock_r))
    else $error("soft reset pulse wrong");

  a_global_off: assert property (@(posedge core_clk) disable iff (rst)
    !gen_r |=> dev_enable == '0)
    else $error("device enabled while global enable low");

  a_enable_follow: assert property (@(posedge core_clk) disable iff (rst)
    gen_r |=> dev_enable == $past(dev_activate))
    else $error("device enable not following activate");

  a_reset_load: assert property (@(posedge core_clk) disable iff (rst)
    $past(rst) |-> gc1_rd == GC1_RESET && ps2_r == PS2_RESET)
    else $error("reset values wrong");

  a_unmapped_err: assert property (@(posedge core_clk) disable iff (rst)
    setup && !reg_hit(paddr, GC1_IDX) && !reg_hit(paddr, PS2_IDX)
      |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");

endmodule // gcps_top

// >>> shared/gcps_pkg.sv
// Purpose: constants for the global config and pin select block
// Assumes: registers sit at word index times four on APB
// Notes: wait-state decode shared by the DMA and I/O fields
package gcps_pkg;

  // Register indexes, byte address is four times the index
  localparam logic [7:0] GC1_IDX = 8'h21;
  localparam logic [7:0] PS2_IDX = 8'h22;

  // Field positions in global_config_one
  localparam int GC1_LOCK_BIT  = 7;
  localparam int GC1_PIRQ_BIT  = 6;
  localparam int GC1_DMA_LSB   = 4;
  localparam int GC1_IO_LSB    = 2;
  localparam int GC1_SWRST_BIT = 1;
  localparam int GC1_GEN_BIT   = 0;
  localparam int WS_W          = 2;

  // Field positions in pin_select_two
  localparam int PS2_PIN1_LSB  = 0;
  localparam int PS2_SINGLE_LSB = 2;

  // Reset values
  localparam logic [7:0] GC1_RESET = 8'h11;
  localparam logic [7:0] PS2_RESET = 8'h00;

  // Wait-state codes and counts
  localparam logic [1:0] WS_CODE_0 = 2'h0;
  localparam logic [1:0] WS_CODE_1 = 2'h1;
  localparam logic [1:0] WS_CODE_2 = 2'h2;
  localparam logic [1:0] WS_CODE_3 = 2'h3;
  localparam logic [3:0] WS_NONE   = 4'h0;
  localparam logic [3:0] WS_TWO    = 4'h2;
  localparam logic [3:0] WS_SIX    = 4'h6;
  localparam logic [3:0] WS_TWELVE = 4'hc;

  // Pin 1 function codes
  localparam logic [1:0] PIN1_GPIO = 2'h0;
  localparam logic [1:0] PIN1_FAN2 = 2'h1;
  localparam logic [1:0] PIN1_HOOD = 2'h2;

  // Code to wait-state count
  function automatic logic [3:0] gcps_ws_count(input logic [1:0] code);
    logic [3:0] n;
    n = WS_NONE;
    case (code)
      WS_CODE_1: n = WS_TWO;
      WS_CODE_2: n = WS_SIX;
      WS_CODE_3: n = WS_TWELVE;
      default:   n = WS_NONE;
    endcase
    return n;
  endfunction

endpackage

// >>> tb/gcps_tb_top.sv
// Purpose: self-checking bench for the config and pin select block
// Assumes: APB answer one cycle after setup, outputs settle in 3 edges
// Notes: far-side pad and function inputs come from one pattern word
`timescale 1ns/1ps
module gcps_tb_top;
  import gcps_pkg::*;

  // Byte addresses, word index times four
  localparam logic [11:0] A1 = {2'b00, GC1_IDX, 2'b00};
  localparam logic [11:0] A2 = {2'b00, PS2_IDX, 2'b00};

  // Bench-driven inputs
  logic        core_clk     = 1'b0;
  logic        rst          = 1'b1;
  logic        psel         = 1'b0;
  logic        penable      = 1'b0;
  logic        pwrite       = 1'b0;
  logic [11:0] paddr        = 12'h000;
  logic [31:0] pwdata       = 32'h0000_0000;
  logic [3:0]  pstrb        = 4'hf;
  logic [7:0]  dev_activate = 8'h5a;
  logic [15:0] pat          = 16'ha5c3;
  // Design outputs
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  dev_enable;
  logic        dev_soft_reset;
  logic        wake_unit_reset;
  logic        pirq_route;
  logic        pin_sel_lock;
  logic [3:0]  dma_wait_count;
  logic [3:0]  io_wait_count;
  logic [6:0]  pad_out;
  logic [6:0]  pad_oe;
  logic [6:0]  gp_in;
  logic        kbc_port_line_17_in;
  logic        kbc_port_line_12_in;
  logic        fan_tach_in_0;
  logic        fan_tach_in_1;
  // Bookkeeping
  int          mismatches = 0;
  int          compares   = 0;
  int          sr_cnt     = 0;
  logic [31:0] rd;
  logic        err;
  logic [3:0]  ws_tab [4] = '{4'h0, 4'h2, 4'h6, 4'hc};
  logic [7:0]  sel_tab [7] = '{8'h00, 8'h54, 8'hab, 8'hfc, 8'hfd, 8'hfe,
                               8'hff};

  // Far-side stimulus fanned out from the pattern word
  wire logic [6:0] gp_out = pat[6:0];
  wire logic [6:0] pad_in = pat[13:7];
  wire logic [6:0] gp_oe  = ~pat[13:7];
  wire logic k17_o = pat[14];
  wire logic k17_e = pat[15];
  wire logic k12_o = ~pat[14];
  wire logic k12_e = ~pat[15];

  // Free-running core clock, 8 ns
  always #4 core_clk = ~core_clk;

  // Soft reset pulse counter, catches stray or stretched pulses
  always @(posedge core_clk)
  begin
    if (dev_soft_reset === 1'b1)
      sr_cnt++;
  end

  gcps_top DUT (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dev_activate(dev_activate), .dev_enable(dev_enable),
    .dev_soft_reset(dev_soft_reset), .wake_unit_reset(wake_unit_reset),
    .pirq_route(pirq_route), .pin_sel_lock(pin_sel_lock),
    .dma_wait_count(dma_wait_count), .io_wait_count(io_wait_count),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .gp_out(gp_out), .gp_oe(gp_oe), .gp_in(gp_in),
    .kbc_port_line_17_out(k17_o), .kbc_port_line_17_oe(k17_e),
    .kbc_port_line_17_in(kbc_port_line_17_in),
    .kbc_port_line_12_out(k12_o), .kbc_port_line_12_oe(k12_e),
    .kbc_port_line_12_in(kbc_port_line_12_in),
    .fan_pwm_out_0(pat[15]), .fan_pwm_out_1(~pat[15]),
    .fan_pwm_out_2(pat[14]), .chassis_hood_lock_out(~pat[14]),
    .fan_tach_in_0(fan_tach_in_0), .fan_tach_in_1(fan_tach_in_1)
  );

  // Verdict and exit, shared by the main flow and every timeout
  task end_sim;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Compare with case equality so unknowns never match
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      chk(pready, 1'b1);
      end_sim;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Let registered decode and pad paths land before looking
  task settle;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  // Expected pad picture for a pin select value
  task pchk(input logic [7:0] s);
    logic [6:0] o, e, g;
    o = gp_out;
    e = gp_oe;
    g = pad_in;
    if (s[7])
    begin
      o[6] = k17_o; e[6] = k17_e; g[6] = 1'b0;
      chk(kbc_port_line_17_in, pad_in[6]);
    end
    if (s[6])
    begin
      o[5] = k12_o; e[5] = k12_e; g[5] = 1'b0;
      chk(kbc_port_line_12_in, pad_in[5]);
    end
    if (s[5])
    begin
      o[4] = pat[15]; e[4] = 1'b1; g[4] = 1'b0;
    end
    if (s[4])
    begin
      e[3] = 1'b0; g[3] = 1'b0;
      chk(fan_tach_in_0, pad_in[3]);
    end
    if (s[3])
    begin
      o[2] = ~pat[15]; e[2] = 1'b1; g[2] = 1'b0;
    end
    if (s[2])
    begin
      e[1] = 1'b0; g[1] = 1'b0;
      chk(fan_tach_in_1, pad_in[1]);
    end
    if (s[1:0] != 2'h0)
    begin
      o[0] = (s[1:0] == 2'h1) ? pat[14] : ~pat[14];
      e[0] = (s[1:0] != 2'h3);
      g[0] = 1'b0;
    end
    chk(pad_oe, e);
    chk(pad_out & e, o & e);
    chk(gp_in, g);
  endtask

  // Main sequence
  initial
  begin
    logic [1:0] c;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    // Reset picture
    apb(1'b0, A1, 8'h00); chk(rd, 32'h0000_0011);
    apb(1'b0, A2, 8'h00); chk(rd, 32'h0000_0000);
    settle;
    chk(dma_wait_count, 4'h2);
    chk(io_wait_count, 4'h0);
    chk(dev_enable, 8'h5a);
    chk(pirq_route, 1'b0);
    // Unmapped word is refused
    apb(1'b0, 12'h08c, 8'h00); chk(err, 1'b1);
    // Wait-state codes one to three in both fields
    for (int i = 1; i < 4; i++)
    begin
      c = i[1:0];
      apb(1'b1, A1, {2'b00, c, c, 2'b01});
      settle;
      chk(dma_wait_count, ws_tab[i]);
      chk(io_wait_count, ws_tab[i]);
      apb(1'b0, A1, 8'h00); chk(rd, {26'h0, c, c, 2'b01});
    end
    // Reserved DMA code keeps the old count, I/O code zero
    apb(1'b1, A1, 8'h01);
    settle;
    chk(dma_wait_count, 4'hc);
    chk(io_wait_count, 4'h0);
    // Write with low strobe off is dropped, soft reset included
    pstrb <= 4'h0;
    apb(1'b1, A1, 8'h17);
    pstrb <= 4'hf;
    apb(1'b0, A1, 8'h00); chk(rd, 32'h0000_0031);
    // Soft reset pulses once and reads back zero
    apb(1'b1, A1, 8'h33);
    #1;
    chk(wake_unit_reset, 1'b1);
    apb(1'b0, A1, 8'h00); chk(rd, 32'h0000_0031);
    chk(sr_cnt, 1);
    // Global enable off masks every device, on follows activate
    apb(1'b1, A1, 8'h30);
    settle;
    chk(dev_enable, 8'h00);
    dev_activate <= 8'ha5;
    settle;
    chk(dev_enable, 8'h00);
    apb(1'b1, A1, 8'h31);
    settle;
    chk(dev_enable, 8'ha5);
    // Pin selections under two far-side patterns
    for (int p = 0; p < 2; p++)
    begin
      pat <= p ? 16'h5a3c : 16'ha5c3;
      for (int k = 0; k < 7; k++)
      begin
        apb(1'b1, A2, sel_tab[k]);
        settle;
        pchk(sel_tab[k]);
        apb(1'b0, A2, 8'h00); chk(rd, {24'h0, sel_tab[k]});
      end
    end
    // Lock plus interrupt routing, then try to undo both
    apb(1'b1, A1, 8'hf1);
    settle;
    chk(pirq_route, 1'b1);
    chk(pin_sel_lock, 1'b1);
    apb(1'b1, A1, 8'h05);
    apb(1'b0, A1, 8'h00); chk(rd, 32'h0000_00f5);
    apb(1'b1, A2, 8'h00); chk(err, 1'b0);
    apb(1'b0, A2, 8'h00); chk(rd, 32'h0000_00ff);
    settle;
    chk(io_wait_count, 4'h2);
    chk(pirq_route, 1'b1);
    pchk(8'hff);
    // Only a hardware reset clears the lock
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, A1, 8'h00); chk(rd, 32'h0000_0011);
    chk(pin_sel_lock, 1'b0);
    end_sim;
  end

endmodule // gcps_tb_top
